// ---- hdl/msr_regs.sv ----
// Status and output register bank of a three-axis motion sensor.
// Assumes detectors, queue engine and bus core all run on sys_clk_in;
// event inputs are one-cycle pulses, mirror inputs are levels.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "msr_cfg.svh"
module msr_regs #(
  parameter logic [21:0] IBI_C50 = 22'(`MSR_C50_US),
  parameter logic [21:0] IBI_C1M = 22'(`MSR_C1_MS),
  parameter logic [21:0] IBI_C25 = 22'(`MSR_C25_MS)
) (
  // Clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  rstn_in,
  // Register port
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic      [7:0]            reg_rdata_out,
  // Detector events
  input  wire msr_pkg::msr_evt_type  evt_in,
  input  wire logic                  sleep_evt_in,
  // Samples
  input  wire logic                  sample_valid_in,
  input  wire msr_pkg::msr_axes_type axes_in,
  input  wire logic [11:0]           temp_in,
  // Queue status
  input  wire logic [7:0]            queue_fill_count_in,
  input  wire logic [6:0]            queue_threshold_level_in,
  input  wire logic                  queue_overrun_in,
  // Mirror inputs
  input  wire logic [3:0]            emb_flags_in,
  input  wire logic [7:0]            state_machine_event_flags_in,
  input  wire logic [3:0]            classifier_event_flags_in,
  // Bus interface events
  input  wire logic                  direct_rstdaa_in,
  input  wire logic                  dyn_addr_assigned_in,
  input  wire logic                  ibi_req_in,
  input  wire logic                  bus_idle_in,
  // Controls
  output logic      [1:0]            selftest_acquire_out,
  output logic                       temperature_chain_off_out,
  output logic                       new_sample_flag_out,
  output logic                       addr_reset_out,
  output logic                       spike_filter_on_out,
  output logic                       ibi_go_out
);

  // Decode
  wire       rd_src_w;
  wire       rd_hi_w;
  wire       wr_stc_w;
  wire       wr_bic_w;
  wire [6:0] evt_w;
  wire       any_evt_w;
  assign rd_src_w  = reg_rd_in && (reg_addr_in == `MSR_A_SRC);
  assign rd_hi_w   = reg_rd_in && ((reg_addr_in == `MSR_A_XH) ||
                                   (reg_addr_in == `MSR_A_YH) ||
                                   (reg_addr_in == `MSR_A_ZH));
  assign wr_stc_w  = reg_wr_in && (reg_addr_in == `MSR_A_STC);
  assign wr_bic_w  = reg_wr_in && (reg_addr_in == `MSR_A_BIC);
  assign evt_w     = evt_in;
  assign any_evt_w = (|evt_w) || sleep_evt_in;

  // Sticky source flags; a new event beats the read clear
  logic [6:0] src_q;
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_src
      wire src_d;
      assign src_d = evt_w[gi] | (src_q[gi] & ~rd_src_w);
      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          src_q[gi] <= 1'h0;
        end else begin
          src_q[gi] <= src_d;
        end
      end
    end
  endgenerate

  // Global event bit and new-sample flag
  logic glob_q;
  logic new_sample_flag_q;
  wire  glob_d;
  wire  new_sample_flag_d;
  assign glob_d = any_evt_w | (glob_q & ~rd_src_w);
  assign new_sample_flag_d = sample_valid_in | (new_sample_flag_q & ~rd_hi_w);

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      glob_q <= 1'h0;
      new_sample_flag_q <= 1'h0;
    end else begin
      glob_q <= glob_d;
      new_sample_flag_q <= new_sample_flag_d;
    end
  end

  // Sample capture; temperature only while its chain runs
  msr_pkg::msr_axes_type axes_q;
  logic [11:0]           temp_q;
  wire                   temp_ld_w;
  assign temp_ld_w = sample_valid_in && !temperature_chain_off_out;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      axes_q <= '0;
    end else if (sample_valid_in) begin
      axes_q <= axes_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      temp_q <= 12'h000;
    end else if (temp_ld_w) begin
      temp_q <= temp_in;
    end
  end

  // Queue status, registered from the engine
  logic       wtm_q;
  logic       ovr_q;
  logic [7:0] fill_q;
  wire        wtm_d;
  assign wtm_d = queue_fill_count_in >= {1'b0, queue_threshold_level_in};

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wtm_q  <= 1'h0;
      ovr_q  <= 1'h0;
      fill_q <= 8'h00;
    end else begin
      wtm_q  <= wtm_d;
      ovr_q  <= queue_overrun_in;
      fill_q <= queue_fill_count_in;
    end
  end

  // Mirrors of embedded, state machine and classifier flags
  logic [3:0] emb_q;
  logic [7:0] fsm_q;
  logic [3:0] mlc_q;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      emb_q <= 4'h0;
      fsm_q <= 8'h00;
      mlc_q <= 4'h0;
    end else begin
      emb_q <= emb_flags_in;
      fsm_q <= state_machine_event_flags_in;
      mlc_q <= classifier_event_flags_in;
    end
  end

  // Writable control
  logic [1:0] ibi_sel_q;
  logic       drst_blk_q;
  logic       asf_q;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      selftest_acquire_out      <= `MSR_R_ST;
      temperature_chain_off_out <= `MSR_R_TDIS;
    end else if (wr_stc_w) begin
      selftest_acquire_out      <= reg_wdata_in[`MSR_B_ST_HI:`MSR_B_ST_LO];
      temperature_chain_off_out <= reg_wdata_in[`MSR_B_TDIS];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      drst_blk_q <= `MSR_R_DRST;
      asf_q      <= `MSR_R_ASF;
      ibi_sel_q  <= `MSR_R_SEL;
    end else if (wr_bic_w) begin
      drst_blk_q <= reg_wdata_in[`MSR_B_DRST];
      asf_q      <= reg_wdata_in[`MSR_B_ASF];
      ibi_sel_q  <= reg_wdata_in[`MSR_B_SEL_HI:`MSR_B_SEL_LO];
    end
  end

  // Bus interface effects
  wire spike_d;
  assign spike_d = asf_q || !dyn_addr_assigned_in;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_reset_out      <= 1'h0;
      spike_filter_on_out <= 1'h1;
      new_sample_flag_out <= 1'h0;
    end else begin
      addr_reset_out      <= direct_rstdaa_in && !drst_blk_q;
      spike_filter_on_out <= spike_d;
      new_sample_flag_out <= new_sample_flag_d;
    end
  end

  // Bus-available wait before an in-band interrupt.
  // Any bus activity restarts the count, so the wait is continuous idle.
  msr_pkg::msr_ibi_type ibi_st_q;
  logic [21:0]          ibi_cnt_q;
  logic [21:0]          ibi_lim_w;
  wire                  ibi_done_w;
  assign ibi_lim_w = (ibi_sel_q == 2'h0) ? 22'(`MSR_C20_US) :
                     (ibi_sel_q == 2'h1) ? IBI_C50 :
                     (ibi_sel_q == 2'h2) ? IBI_C1M : IBI_C25;
  assign ibi_done_w = bus_idle_in && (ibi_cnt_q == ibi_lim_w - 22'h00_0001);

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ibi_st_q   <= msr_pkg::MSR_IBI_IDLE;
      ibi_cnt_q  <= 22'h00_0000;
      ibi_go_out <= 1'h0;
    end else begin
      ibi_go_out <= 1'h0;
      case (ibi_st_q)
        msr_pkg::MSR_IBI_IDLE: begin
          ibi_cnt_q <= 22'h00_0000;
          if (ibi_req_in) begin
            ibi_st_q <= msr_pkg::MSR_IBI_WAIT;
          end
        end
        msr_pkg::MSR_IBI_WAIT: begin
          if (!bus_idle_in) begin
            ibi_cnt_q <= 22'h00_0000;
          end else if (ibi_done_w) begin
            ibi_go_out <= 1'h1;
            ibi_st_q   <= msr_pkg::MSR_IBI_IDLE;
          end else begin
            ibi_cnt_q <= ibi_cnt_q + 22'h00_0001;
          end
        end
        default: begin
          ibi_st_q <= msr_pkg::MSR_IBI_IDLE;
        end
      endcase
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  wire [7:0] rd_mux_w;
  wire [7:0] stat_w;
  wire [7:0] qflg_w;
  wire [7:0] stc_w;
  wire [7:0] bic_w;
  wire [7:0] emb_w;
  assign stat_w = {2'b00, glob_q, 4'b0000, new_sample_flag_q};
  assign qflg_w = {wtm_q, ovr_q, 6'b00_0000};
  assign stc_w  = {2'b00, selftest_acquire_out, 3'b000, temperature_chain_off_out};
  assign bic_w  = {drst_blk_q, asf_q, 4'b0000, ibi_sel_q};
  assign emb_w  = {emb_q[3], 1'b0, emb_q[2:0], 3'b000};
  assign rd_mux_w =
    (reg_addr_in == `MSR_A_SRC)   ? {1'b0, src_q} :
    (reg_addr_in == `MSR_A_STAT)  ? stat_w :
    (reg_addr_in == `MSR_A_QFLG)  ? qflg_w :
    (reg_addr_in == `MSR_A_QFILL) ? fill_q :
    (reg_addr_in == `MSR_A_XL)    ? axes_q.x[7:0] :
    (reg_addr_in == `MSR_A_XH)    ? axes_q.x[15:8] :
    (reg_addr_in == `MSR_A_YL)    ? axes_q.y[7:0] :
    (reg_addr_in == `MSR_A_YH)    ? axes_q.y[15:8] :
    (reg_addr_in == `MSR_A_ZL)    ? axes_q.z[7:0] :
    (reg_addr_in == `MSR_A_ZH)    ? axes_q.z[15:8] :
    (reg_addr_in == `MSR_A_TL)    ? {temp_q[3:0], 4'h0} :
    (reg_addr_in == `MSR_A_TH)    ? temp_q[11:4] :
    (reg_addr_in == `MSR_A_STC)   ? stc_w :
    (reg_addr_in == `MSR_A_BIC)   ? bic_w :
    (reg_addr_in == `MSR_A_EMB)   ? emb_w :
    (reg_addr_in == `MSR_A_FSM)   ? fsm_q :
    (reg_addr_in == `MSR_A_MLC)   ? {4'h0, mlc_q} : 8'h00;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux_w;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  a_src_event_set: assert property (
    evt_in.tap3 |=> src_q[4] && glob_q)
    else $error("tap event not latched");

  a_src_read_clear: assert property (
    rd_src_w && !evt_in.freefall && !sleep_evt_in |=> !src_q[0])
    else $error("free-fall flag not cleared by read");

  a_src_readback: assert property (
    reg_rd_in && reg_addr_in == `MSR_A_SRC |=> reg_rdata_out == {1'b0, $past(src_q)})
    else $error("source byte mismatch");

  a_global_sleep: assert property (
    sleep_evt_in |=> glob_q)
    else $error("sleep event missed global bit");

  // Readback shows the bit as it stood when the read was taken
  a_global_readback: assert property (
    reg_rd_in && reg_addr_in == `MSR_A_STAT |=> reg_rdata_out[`MSR_B_GLOBAL] == $past(glob_q))
    else $error("global bit readback mismatch");

  a_new_sample_flag_hold: assert property (
    new_sample_flag_q && !rd_hi_w && !sample_valid_in |=> new_sample_flag_q)
    else $error("new sample flag dropped early");

  a_new_sample_flag_clear: assert property (
    rd_hi_w && !sample_valid_in |=> !new_sample_flag_q && !new_sample_flag_out)
    else $error("new sample flag not cleared");

  a_wtm_level: assert property (
    queue_fill_count_in >= {1'b0, queue_threshold_level_in} |=> wtm_q)
    else $error("threshold flag missing");

  a_temp_nibble: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == `MSR_A_TL |-> reg_rdata_out[3:0] == 4'h0)
    else $error("temperature low nibble not zero");

  a_temp_frozen: assert property (
    temperature_chain_off_out |=> temp_q == $past(temp_q))
    else $error("temperature captured while chain off");

  a_rstdaa_block: assert property (
    direct_rstdaa_in |=> addr_reset_out == !$past(drst_blk_q))
    else $error("direct address reset gating wrong");

  a_spike_force: assert property (
    asf_q && $stable(asf_q) |=> spike_filter_on_out)
    else $error("spike filter not forced on");

  a_spike_unaddressed: assert property (
    !dyn_addr_assigned_in |=> spike_filter_on_out)
    else $error("spike filter off before addressing");

  a_ibi_wait: assert property (
    ibi_go_out |-> $past(ibi_cnt_q) == $past(ibi_lim_w) - 22'h00_0001 && $past(bus_idle_in))
    else $error("in-band interrupt before idle time");

  a_cls_upper: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == `MSR_A_MLC |-> reg_rdata_out[7:4] == 4'h0)
    else $error("classifier upper bits not zero");

endmodule : msr_regs
`default_nettype wire

// ---- hdl/msr_cfg.svh ----
// Offsets, field positions, reset values and timing counts
// of the motion status register bank. Definitions only.
`ifndef MSR_CFG_SVH
`define MSR_CFG_SVH
// Register offsets
`define MSR_A_SRC    8'h24
`define MSR_A_STAT   8'h25
`define MSR_A_QFLG   8'h26
`define MSR_A_QFILL  8'h27
`define MSR_A_XL     8'h28
`define MSR_A_XH     8'h29
`define MSR_A_YL     8'h2a
`define MSR_A_YH     8'h2b
`define MSR_A_ZL     8'h2c
`define MSR_A_ZH     8'h2d
`define MSR_A_TL     8'h2e
`define MSR_A_TH     8'h2f
`define MSR_A_STC    8'h32
`define MSR_A_BIC    8'h33
`define MSR_A_EMB    8'h34
`define MSR_A_FSM    8'h35
`define MSR_A_MLC    8'h36
// Field positions
`define MSR_B_GLOBAL 5
`define MSR_B_NEW_SAMPLE_FLAG   0
`define MSR_B_WTM    7
`define MSR_B_OVR    6
`define MSR_B_ST_HI  5
`define MSR_B_ST_LO  4
`define MSR_B_TDIS   0
`define MSR_B_DRST   7
`define MSR_B_ASF    6
`define MSR_B_SEL_HI 1
`define MSR_B_SEL_LO 0
// Reset values
`define MSR_R_ST     2'h0
`define MSR_R_TDIS   1'h0
`define MSR_R_DRST   1'h0
`define MSR_R_ASF    1'h0
`define MSR_R_SEL    2'h1
// Timing
`define MSR_CLK_MHZ  100
`define MSR_T20_US   20
`define MSR_T50_US   50
`define MSR_T1_MS    1
`define MSR_T25_MS   25
`define MSR_C20_US   (`MSR_T20_US * `MSR_CLK_MHZ)
`define MSR_C50_US   (`MSR_T50_US * `MSR_CLK_MHZ)
`define MSR_C1_MS    (`MSR_T1_MS * 1000 * `MSR_CLK_MHZ)
`define MSR_C25_MS   (`MSR_T25_MS * 1000 * `MSR_CLK_MHZ)
`endif

// ---- hdl/msr_pkg.sv ----
// Types of the motion status register bank.
// Used by qualified name only.
`default_nettype none
package msr_pkg;
  // Detector pulses, bit order as in the source byte
  typedef struct packed {
    logic sleep_chg;
    logic orient;
    logic tap3;
    logic tap2;
    logic tap1;
    logic wakeup;
    logic freefall;
  } msr_evt_type;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } msr_axes_type;

  typedef enum logic {
    MSR_IBI_IDLE,
    MSR_IBI_WAIT
  } msr_ibi_type;
endpackage : msr_pkg
`default_nettype wire

// ---- verification/msr_host_model.sv ----
// Host side of the register port: a plain bus master model.
// Assumes it shares sys_clk_in with the register bank.
`timescale 1ns/10ps
`default_nettype none
module msr_host_model (
  // Clock
  input  wire logic       sys_clk_in,
  // Register port
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  input  wire logic [7:0] reg_rdata_in
);
  initial begin
    reg_addr_out  = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end

  // Control fields such as self-test are set through here
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_out    <= 1'b0;
    // Released data must not look valid
    reg_wdata_out <= ~d;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_out   <= 1'b0;
    @(negedge sys_clk_in);
    d = reg_rdata_in;
  endtask : rd
endmodule : msr_host_model
`default_nettype wire

// ---- verification/test_motion_status_output_regs.sv ----
// Self-checking bench of the motion status register bank.
// Assumes short in-band interrupt counts of 8, 16 and 32 cycles.
`timescale 1ns/10ps
`default_nettype none
`include "msr_cfg.svh"
module test_motion_status_output_regs;
  logic                  sys_clk_in, rstn_in, sleep_evt_in, sample_valid_in, queue_overrun_in;
  logic                  direct_rstdaa_in, dyn_addr_assigned_in, ibi_req_in, bus_idle_in;
  logic                  reg_wr_in, reg_rd_in;
  logic [7:0]            reg_addr_in, reg_wdata_in, reg_rdata_out, queue_fill_count_in;
  logic [7:0]            state_machine_event_flags_in, rd_val;
  logic [6:0]            queue_threshold_level_in;
  logic [3:0]            emb_flags_in, classifier_event_flags_in;
  logic [11:0]           temp_in, tv;
  logic [1:0]            selftest_acquire_out;
  logic                  temperature_chain_off_out, new_sample_flag_out, addr_reset_out;
  logic                  spike_filter_on_out, ibi_go_out;
  msr_pkg::msr_evt_type  evt_in;
  msr_pkg::msr_axes_type axes_in, ax;
  logic [15:0]           av [3];
  integer                seed = 32'hdd7b_6fc9;
  int                    bad_count = 0, checked = 0, cnt;

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  msr_host_model u_msr_host_model (.sys_clk_in(sys_clk_in), .reg_addr_out(reg_addr_in),
    .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
    .reg_rdata_in(reg_rdata_out));

  msr_regs #(.IBI_C50(22'h8), .IBI_C1M(22'h10), .IBI_C25(22'h20)) u_msr_regs (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .evt_in(evt_in), .sleep_evt_in(sleep_evt_in),
    .sample_valid_in(sample_valid_in), .axes_in(axes_in), .temp_in(temp_in),
    .queue_fill_count_in(queue_fill_count_in), .queue_threshold_level_in(queue_threshold_level_in),
    .queue_overrun_in(queue_overrun_in), .emb_flags_in(emb_flags_in),
    .state_machine_event_flags_in(state_machine_event_flags_in),
    .classifier_event_flags_in(classifier_event_flags_in), .direct_rstdaa_in(direct_rstdaa_in),
    .dyn_addr_assigned_in(dyn_addr_assigned_in), .ibi_req_in(ibi_req_in), .bus_idle_in(bus_idle_in),
    .selftest_acquire_out(selftest_acquire_out), .temperature_chain_off_out(temperature_chain_off_out),
    .new_sample_flag_out(new_sample_flag_out), .addr_reset_out(addr_reset_out),
    .spike_filter_on_out(spike_filter_on_out), .ibi_go_out(ibi_go_out));

  function automatic int ibi_n(input logic [1:0] s);
    return (s == 2'h0) ? `MSR_C20_US : (s == 2'h1) ? 8 : (s == 2'h2) ? 16 : 32;
  endfunction : ibi_n

  task automatic give_verdict;
    $display("counts: checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
    u_msr_host_model.rd(a, rd_val);
    check_byte($sformatf("register %h", a), exp, rd_val);
  endtask : check_reg

  task automatic pulse_evt(input logic [6:0] v, input logic slp);
    @(posedge sys_clk_in);
    evt_in       <= v;
    sleep_evt_in <= slp;
    @(posedge sys_clk_in);
    evt_in       <= 7'h00;
    sleep_evt_in <= 1'b0;
  endtask : pulse_evt

  task automatic new_sample(input msr_pkg::msr_axes_type a, input logic [11:0] t);
    @(posedge sys_clk_in);
    axes_in         <= a;
    temp_in         <= t;
    sample_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    sample_valid_in <= 1'b0;
  endtask : new_sample

  initial begin
    {sleep_evt_in, sample_valid_in, queue_overrun_in, direct_rstdaa_in, ibi_req_in} = 5'h00;
    {evt_in, axes_in, temp_in, queue_fill_count_in, queue_threshold_level_in} = '0;
    {emb_flags_in, state_machine_event_flags_in, classifier_event_flags_in} = 16'h0000;
    dyn_addr_assigned_in = 1'b1;
    bus_idle_in = 1'b1;
    rstn_in = 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    check_reg(`MSR_A_STC, 8'h00);
    check_reg(`MSR_A_BIC, 8'h01);
    check_reg(`MSR_A_SRC, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 9; i++) begin
      // Each event alone, then random groups of events
      ax.x = (i < 7) ? 16'(1 << i) : 16'($random(seed) | 1);
      pulse_evt(ax.x[6:0], 1'b0);
      check_reg(`MSR_A_STAT, 8'h20);
      check_reg(`MSR_A_SRC, {1'b0, ax.x[6:0]});
      check_reg(`MSR_A_SRC, 8'h00);
    end
    pulse_evt(7'h00, 1'b1);
    check_reg(`MSR_A_STAT, 8'h20);
    check_reg(`MSR_A_SRC, 8'h00);
    check_reg(`MSR_A_STAT, 8'h00);
    $display("test events done");
    for (int k = 0; k < 3; k++) begin
      ax = (k == 0) ? {16'h8000, 16'h7fff, 16'hffff} : {$random(seed), 16'($random(seed))};
      tv = 12'($random(seed));
      av = '{ax.x, ax.y, ax.z};
      new_sample(ax, tv);
      @(negedge sys_clk_in);
      check_byte("new sample flag", 8'h01, {7'h00, new_sample_flag_out});
      check_reg(`MSR_A_STAT, 8'h01);
      for (int j = 0; j < 3; j++) check_reg(8'(`MSR_A_XL + 2 * j), av[j][7:0]);
      check_reg(`MSR_A_TL, {tv[3:0], 4'h0});
      check_reg(`MSR_A_TH, tv[11:4]);
      check_reg(8'(`MSR_A_XH + 2 * k), av[k][15:8]);
      check_reg(`MSR_A_STAT, 8'h00);
      for (int j = 0; j < 3; j++) check_reg(8'(`MSR_A_XH + 2 * j), av[j][15:8]);
    end
    u_msr_host_model.wr(`MSR_A_STC, 8'h01);
    @(negedge sys_clk_in);
    check_byte("temperature off", 8'h01, {7'h00, temperature_chain_off_out});
    new_sample(ax, ~tv);
    check_reg(`MSR_A_TH, tv[11:4]);
    for (int s = 0; s < 4; s++) begin
      u_msr_host_model.wr(`MSR_A_STC, {2'h0, 2'(s), 4'h0});
      check_reg(`MSR_A_STC, {2'h0, 2'(s), 4'h0});
      check_byte("selftest field", 8'(s), {6'h00, selftest_acquire_out});
    end
    $display("test samples done");
    for (int n = 0; n < 6; n++) begin
      @(posedge sys_clk_in);
      queue_threshold_level_in <= 7'($random(seed));
      queue_overrun_in         <= 1'($random(seed));
      @(posedge sys_clk_in);
      queue_fill_count_in <= (n == 0) ? {1'b0, queue_threshold_level_in} :
                             (n == 1) ? {1'b0, queue_threshold_level_in} - 8'h01 :
                             (n == 2) ? 8'hff : 8'($random(seed));
      emb_flags_in                 <= 4'($random(seed));
      state_machine_event_flags_in <= 8'($random(seed));
      classifier_event_flags_in    <= 4'($random(seed));
      repeat (2) @(posedge sys_clk_in);
      check_reg(`MSR_A_QFLG, {queue_fill_count_in >= {1'b0, queue_threshold_level_in},
                              queue_overrun_in, 6'h00});
      check_reg(`MSR_A_QFILL, queue_fill_count_in);
      check_reg(`MSR_A_EMB, {emb_flags_in[3], 1'b0, emb_flags_in[2:0], 3'h0});
      check_reg(`MSR_A_FSM, state_machine_event_flags_in);
      check_reg(`MSR_A_MLC, {4'h0, classifier_event_flags_in});
    end
    u_msr_host_model.wr(`MSR_A_SRC, 8'hff);
    check_reg(`MSR_A_SRC, 8'h00);
    check_reg(8'h30, 8'h00);
    $display("test queue and mirrors done");
    for (int v = 0; v < 4; v++) begin
      u_msr_host_model.wr(`MSR_A_BIC, {2'(v), 6'h01});
      check_reg(`MSR_A_BIC, {2'(v), 6'h01});
      check_byte("spike filter", {7'h00, v[0]}, {7'h00, spike_filter_on_out});
      @(posedge sys_clk_in);
      direct_rstdaa_in <= 1'b1;
      @(posedge sys_clk_in);
      direct_rstdaa_in <= 1'b0;
      cnt = 0;
      repeat (4) begin
        @(negedge sys_clk_in);
        cnt += int'(addr_reset_out === 1'b1);
      end
      check_byte("address reset pulses", {7'h00, ~v[1]}, 8'(cnt));
    end
    $display("test bus control done");
    for (int s = 0; s < 4; s++) begin
      u_msr_host_model.wr(`MSR_A_BIC, {6'h00, 2'(s)});
      @(posedge sys_clk_in);
      ibi_req_in <= 1'b1;
      @(posedge sys_clk_in);
      ibi_req_in <= 1'b0;
      cnt = 0;
      do begin
        @(negedge sys_clk_in);
        cnt++;
        // One busy cycle in the last setting restarts the wait
        bus_idle_in <= !(s == 3 && cnt == 4);
      end while (ibi_go_out !== 1'b1 && cnt < 3000);
      check_byte("idle wait cycles", 8'h01, {7'h00, cnt == ibi_n(2'(s)) + ((s == 3) ? 5 : 1)});
    end
    @(posedge sys_clk_in);
    dyn_addr_assigned_in <= 1'b0;
    repeat (2) @(negedge sys_clk_in);
    check_byte("spike filter unaddressed", 8'h01, {7'h00, spike_filter_on_out});
    $display("test in-band interrupt done");
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge sys_clk_in);
    bad_count++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule : test_motion_status_output_regs
`default_nettype wire
